//--- hdl/hsr_seq.sv
// Contract
// - The homing method is taken from writes to object 6098 subindex 00h and each of codes 27 to 30, 33 and 34 maps to one fixed sequence.
// - Method 27 with switch off searches reverse fast for a rising edge, decelerates, then stops on a slow forward falling edge.
// - Method 27 hitting the reverse limit searches forward fast for a falling edge, decelerates, then stops on a slow reverse rising edge.
// - Method 27 with switch on at start skips the fast phase and stops on a slow forward falling edge.
// - Method 28 searches reverse fast for a rising edge (skipped if switch on), then slow forward falling, then stops on slow reverse rising.
// - Method 28 hitting the reverse limit searches forward fast for a falling edge, decelerates, then stops on a slow reverse rising edge.
// - Method 29 searches reverse fast for a falling edge, decelerates, then stops on a slow forward rising edge.
// - Method 29 hitting the reverse limit goes forward fast for a rising edge, then slow reverse falling, then stops on slow forward rising.
// - Method 30 searches reverse fast falling, decelerates, slow forward rising, then stops on a slow reverse falling edge.
// - Method 30 hitting the reverse limit searches forward fast for a rising edge, decelerates, then stops on slow reverse falling.
// - Method codes 31 and 32 are reserved and run no sequence.
// - Method 33 moves reverse and stops at the first index pulse, ignoring the switch; a high reverse limit ends it in the error state.
// - Method 34 moves forward and stops at the first index pulse, ignoring switch and limits.
// - The switch edge that ends the fast search is the deceleration point, after which the search continues at low speed.
// - A high reverse limit forbids reverse motion.
`timescale 1ns/100ps
`include "hsr_consts.svh"

module hsr_seq
   import hsr_pkg::*;
(
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   // object write port
   input  wire logic        OBJ_WR_STB,
   input  wire logic [15:0] OBJ_INDEX,
   input  wire logic [7:0]  OBJ_SUB,
   input  wire logic [7:0]  OBJ_DATA,
   // control and motion feedback
   input  wire logic        START,
   input  wire logic        ZERO_SPEED,
   input  wire logic [31:0] POSITION,
   // sensor pins
   input  wire logic        HOME_SWITCH_INPUT,
   input  wire logic        REVERSE_TRAVEL_LIMIT_INPUT,
   input  wire logic        INDEX_INPUT,
   // motion command
   output logic             MOVE_EN,
   output logic             MOVE_DIR,
   output logic             MOVE_HIGH,
   // status
   output logic             BUSY,
   output logic             HOMING_DONE_OUTPUT,
   output logic             METHOD_ERR,
   output logic [31:0]      HOME_POS
);

   // ==========================================================
   // pin synchronisers
   logic sw_lvl;
   logic lim_lvl;
   logic idx_lvl;
   logic sw_d_reg;
   logic idx_d_reg;

   hsr_sync u_sw  (.clk(CORE_CLK), .rst_n(RST_N), .din(HOME_SWITCH_INPUT),          .level(sw_lvl));
   hsr_sync u_lim (.clk(CORE_CLK), .rst_n(RST_N), .din(REVERSE_TRAVEL_LIMIT_INPUT), .level(lim_lvl));
   hsr_sync u_idx (.clk(CORE_CLK), .rst_n(RST_N), .din(INDEX_INPUT),                .level(idx_lvl));

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sw_d_reg  <= 1'b0;
         idx_d_reg <= 1'b0;
      end else begin
         sw_d_reg  <= sw_lvl;
         idx_d_reg <= idx_lvl;
      end
   end

   logic sw_rise;
   logic sw_fall;
   logic idx_rise;

   assign sw_rise  = sw_lvl & ~sw_d_reg;
   assign sw_fall  = ~sw_lvl & sw_d_reg;
   assign idx_rise = idx_lvl & ~idx_d_reg;

   // ==========================================================
   // method selection
   hsr_state_e  state_reg;
   hsr_state_e  state_next;
   logic [7:0]  method_reg;
   logic        path_reg;
   logic        path_next;
   logic [1:0]  step_reg;
   logic [1:0]  step_next;

   // writes are ignored while a search runs so the sequence cannot change under the motor
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         method_reg <= `HSR_METHOD_RST;
      end else if (OBJ_WR_STB && !BUSY && OBJ_INDEX == `HSR_OBJ_INDEX && OBJ_SUB == `HSR_OBJ_SUB) begin
         method_reg <= OBJ_DATA;
      end
   end

   logic method_ok;

   // 31, 32 and anything outside 27..34 fall through to the error state
   assign method_ok = (method_reg >= `HSR_M27 && method_reg <= `HSR_M30) ||
                      method_reg == `HSR_M33 || method_reg == `HSR_M34;

   // ==========================================================
   // step table, bits are {last, index, rise, high, fwd}; path 1 is the limit turnaround
   function automatic hsr_step_s step_cfg(input logic [7:0] m, input logic p, input logic [1:0] s);
      logic [4:0] v;
      v = 5'h00;
      if (m == `HSR_M27) begin
         if (!p) v = (s == 2'd0) ? 5'b00110 : 5'b10001;
         else    v = (s == 2'd0) ? 5'b00011 : 5'b10100;
      end else if (m == `HSR_M28) begin
         if (!p) v = (s == 2'd0) ? 5'b00110 : (s == 2'd1) ? 5'b00001 : 5'b10100;
         else    v = (s == 2'd0) ? 5'b00011 : 5'b10100;
      end else if (m == `HSR_M29) begin
         if (!p) v = (s == 2'd0) ? 5'b00010 : 5'b10101;
         else    v = (s == 2'd0) ? 5'b00111 : (s == 2'd1) ? 5'b00000 : 5'b10101;
      end else if (m == `HSR_M30) begin
         if (!p) v = (s == 2'd0) ? 5'b00010 : (s == 2'd1) ? 5'b00101 : 5'b10000;
         else    v = (s == 2'd0) ? 5'b00111 : 5'b10000;
      end else if (m == `HSR_M33) begin
         v = 5'b11000;
      end else if (m == `HSR_M34) begin
         v = 5'b11001;
      end
      return hsr_step_s'(v);
   endfunction

   hsr_step_s cur;
   hsr_step_s nxt;
   logic      hit;
   logic      lim_turn;
   logic      lim_block;

   assign cur = step_cfg(method_reg, path_reg, step_reg);
   assign nxt = step_cfg(method_reg, path_next, step_next);
   assign hit = cur.index ? idx_rise : (cur.rise ? sw_rise : sw_fall);

   // only the fast reverse search of 27..30 may turn at the limit; any other reverse move blocked there fails
   assign lim_turn  = lim_lvl && !cur.fwd && cur.high && !path_reg && !cur.index;
   assign lim_block = lim_lvl && !cur.fwd && !lim_turn;

   // ==========================================================
   // sequencer
   always_comb begin
      state_next = state_reg;
      path_next  = path_reg;
      step_next  = step_reg;
      case (state_reg)
         HSR_IDLE, HSR_DONE, HSR_FAIL: begin
            if (START) begin
               path_next = 1'b0;
               step_next = 2'd0;
               if (!method_ok) begin
                  state_next = HSR_FAIL;
               end else begin
                  state_next = HSR_SEARCH;
                  if (sw_lvl && (method_reg == `HSR_M27 || method_reg == `HSR_M28)) begin
                     step_next = 2'd1;
                  end
               end
            end
         end
         HSR_SEARCH: begin
            if (lim_turn) begin
               state_next = HSR_DECEL;
               path_next  = 1'b1;
               step_next  = 2'd0;
            end else if (lim_block) begin
               state_next = HSR_FAIL;
            end else if (hit) begin
               if (cur.last) begin
                  state_next = HSR_DONE;
               end else begin
                  state_next = HSR_DECEL;
                  step_next  = step_reg + 2'd1;
               end
            end
         end
         HSR_DECEL: begin
            if (ZERO_SPEED) begin
               state_next = HSR_SEARCH;
            end
         end
         default: begin
            state_next = HSR_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg <= HSR_IDLE;
         path_reg  <= 1'b0;
         step_reg  <= 2'd0;
      end else begin
         state_reg <= state_next;
         path_reg  <= path_next;
         step_reg  <= step_next;
      end
   end

   // ==========================================================
   // motion command
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         MOVE_EN   <= 1'b0;
         MOVE_DIR  <= 1'b0;
         MOVE_HIGH <= 1'b0;
         BUSY      <= 1'b0;
      end else begin
         MOVE_EN   <= state_next == HSR_SEARCH && !(lim_lvl && !nxt.fwd);
         MOVE_DIR  <= nxt.fwd;
         MOVE_HIGH <= nxt.high;
         BUSY      <= state_next == HSR_SEARCH || state_next == HSR_DECEL;
      end
   end

   // ==========================================================
   // status and home capture
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         HOMING_DONE_OUTPUT <= 1'b0;
         METHOD_ERR         <= 1'b0;
         HOME_POS           <= `HSR_POS_RST;
      end else begin
         HOMING_DONE_OUTPUT <= state_next == HSR_DONE;
         METHOD_ERR         <= state_next == HSR_FAIL;
         if (state_reg == HSR_SEARCH && state_next == HSR_DONE) begin
            HOME_POS <= POSITION;
         end
      end
   end

   // ==========================================================
   // checks
   sequence s_lim_hit;
      state_reg == HSR_SEARCH && lim_turn;
   endsequence

   sequence s_turned;
      state_reg == HSR_DECEL && path_reg && step_reg == 2'd0 && !MOVE_EN;
   endsequence

   chk_limit_turn: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      s_lim_hit |=> s_turned) else $error("limit did not start turnaround");

   chk_rev_block: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      ($past(lim_lvl) && !MOVE_DIR) |-> !MOVE_EN) else $error("reverse motion with limit active");

   chk_done_capture: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      $rose(HOMING_DONE_OUTPUT) |-> HOME_POS == $past(POSITION)) else $error("home position not captured");

   chk_last_done: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_reg == HSR_SEARCH && cur.last && hit && !lim_lvl) |=> HOMING_DONE_OUTPUT && !BUSY)
      else $error("final edge did not complete homing");

   chk_reserved_err: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_reg != HSR_SEARCH && state_reg != HSR_DECEL && START &&
       (method_reg == `HSR_M31 || method_reg == `HSR_M32))
      |=> METHOD_ERR && !MOVE_EN) else $error("reserved method not refused");

   chk_skip_fast: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_reg != HSR_SEARCH && state_reg != HSR_DECEL && START && sw_lvl && method_reg == `HSR_M27)
      |=> MOVE_DIR && !MOVE_HIGH && MOVE_EN) else $error("method 27 did not skip fast phase");

   chk_fast_decel: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_reg == HSR_SEARCH && cur.high && hit && !lim_lvl) |=> state_reg == HSR_DECEL ##1 !MOVE_HIGH)
      else $error("fast edge did not lead to deceleration");

   chk_index_dir: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_reg == HSR_SEARCH && method_reg == `HSR_M33) |-> !MOVE_DIR && !MOVE_HIGH)
      else $error("method 33 not moving reverse");

   chk_index_fwd: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
      (state_reg == HSR_SEARCH && method_reg == `HSR_M34) |-> MOVE_DIR && MOVE_EN)
      else $error("method 34 not moving forward");

endmodule

//--- hdl/hsr_consts.svh
`ifndef HSR_CONSTS_SVH
`define HSR_CONSTS_SVH

// homing method object address
`define HSR_OBJ_INDEX 16'h6098
`define HSR_OBJ_SUB   8'h00

// method codes
`define HSR_M27 8'h1B
`define HSR_M28 8'h1C
`define HSR_M29 8'h1D
`define HSR_M30 8'h1E
`define HSR_M31 8'h1F
`define HSR_M32 8'h20
`define HSR_M33 8'h21
`define HSR_M34 8'h22

// reset values
`define HSR_METHOD_RST 8'h00
`define HSR_POS_RST    32'h00000000

`endif

//--- hdl/hsr_pkg.sv
package hsr_pkg;

   typedef enum logic [2:0] {
      HSR_IDLE,
      HSR_SEARCH,
      HSR_DECEL,
      HSR_DONE,
      HSR_FAIL
   } hsr_state_e;

   // one search step: stop here, edge source, edge polarity, speed, direction
   typedef struct packed {
      logic last;
      logic index;
      logic rise;
      logic high;
      logic fwd;
   } hsr_step_s;

endpackage

//--- hdl/hsr_sync.sv
`timescale 1ns/100ps

module hsr_sync (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // pin side
   input  wire logic din,
   // core side
   output logic      level
);

   logic ff1_reg;
   logic ff2_reg;
   logic ff3_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ff1_reg <= 1'b0;
         ff2_reg <= 1'b0;
         ff3_reg <= 1'b0;
      end else begin
         ff1_reg <= din;
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
      end
   end

   // a change counts only once the last two stages agree
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         level <= 1'b0;
      end else if (ff2_reg == ff3_reg) begin
         level <= ff3_reg;
      end
   end

endmodule

//--- sim/hsr_motor.sv
`timescale 1ns/100ps

module hsr_motor #(
   parameter logic [31:0] SW_LO   = 32'h00000064,
   parameter logic [31:0] SW_HI   = 32'h0000008C,
   parameter logic [31:0] LIM_POS = 32'h00000028
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // bench preset of the shaft
   input  wire logic        load_en,
   input  wire logic [31:0] load_val,
   // motion command
   input  wire logic        move_en,
   input  wire logic        move_dir,
   input  wire logic        move_high,
   // feedback
   output logic [31:0]      pos_reg,
   output logic             zero_speed,
   output logic             home_sw,
   output logic             rev_lim,
   output logic             index_p
);
   logic [1:0] idle_reg;

   // ==========================================
   // shaft
   // the motor does not honour the limit itself: stopping there is the drive's job
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_reg <= 32'h000000C8;
      end else if (load_en) begin
         pos_reg <= load_val;
      end else if (move_en) begin
         pos_reg <= move_dir ? pos_reg + (move_high ? 32'h4 : 32'h1) : pos_reg - (move_high ? 32'h4 : 32'h1);
      end
   end

   // rest is reported two cycles after the command drops, never at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_reg <= 2'h0;
      end else if (move_en) begin
         idle_reg <= 2'h0;
      end else if (idle_reg != 2'h2) begin
         idle_reg <= idle_reg + 2'h1;
      end
   end

   // ==========================================
   // sensors
   assign zero_speed = (idle_reg == 2'h2);
   // switch band is wide enough to be seen on a fast pass
   assign home_sw = (pos_reg >= SW_LO) && (pos_reg <= SW_HI);
   assign rev_lim = (pos_reg <= LIM_POS);
   // four counts wide so a slow pass outlasts the synchroniser
   assign index_p = (pos_reg[5:0] < 6'h04);
endmodule

//--- sim/hsr_seq_tb.sv
`timescale 1ns/100ps
`include "hsr_consts.svh"

module hsr_seq_tb;
   logic        clk;
   logic        rst_n;
   logic        wr_stb;
   logic [15:0] obj_index;
   logic [7:0]  obj_sub;
   logic [7:0]  obj_data;
   logic        start;
   logic        load_en;
   logic [31:0] load_val;
   logic [31:0] position;
   logic        zero_speed;
   logic        home_sw;
   logic        rev_lim;
   logic        index_p;
   logic        move_en;
   logic        move_dir;
   logic        move_high;
   logic        busy;
   logic        done;
   logic        merr;
   logic [31:0] home_pos;
   int          err_total;
   int          compares;

   hsr_seq uut (.CORE_CLK(clk), .RST_N(rst_n), .OBJ_WR_STB(wr_stb), .OBJ_INDEX(obj_index),
      .OBJ_SUB(obj_sub), .OBJ_DATA(obj_data), .START(start), .ZERO_SPEED(zero_speed),
      .POSITION(position), .HOME_SWITCH_INPUT(home_sw), .REVERSE_TRAVEL_LIMIT_INPUT(rev_lim),
      .INDEX_INPUT(index_p), .MOVE_EN(move_en), .MOVE_DIR(move_dir), .MOVE_HIGH(move_high),
      .BUSY(busy), .HOMING_DONE_OUTPUT(done), .METHOD_ERR(merr), .HOME_POS(home_pos));

   hsr_motor motor (.clk(clk), .rst_n(rst_n), .load_en(load_en), .load_val(load_val),
      .move_en(move_en), .move_dir(move_dir), .move_high(move_high), .pos_reg(position),
      .zero_speed(zero_speed), .home_sw(home_sw), .rev_lim(rev_lim), .index_p(index_p));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ==========================================
   // helpers
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic cmp_bit(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s exp %b got %b", name, exp, got);
      end
   endtask

   task automatic cmp_pos(input logic [31:0] lo, input logic [31:0] hi);
      compares++;
      if ((home_pos >= lo && home_pos <= hi) !== 1'b1) begin
         err_total++;
         $display("unexpected home_pos exp %0d..%0d got %0d", lo, hi, home_pos);
      end
   endtask

   task automatic wr_obj(input logic [15:0] idx, input logic [7:0] sub, input logic [7:0] code);
      @(posedge clk);
      wr_stb    <= 1'b1;
      obj_index <= idx;
      obj_sub   <= sub;
      obj_data  <= code;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   // park the shaft, let the pin synchronisers settle, then pulse start
   task automatic place_go(input logic [31:0] p);
      @(posedge clk);
      load_en  <= 1'b1;
      load_val <= p;
      @(posedge clk);
      load_en <= 1'b0;
      repeat (6) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      @(negedge clk);
   endtask

   task automatic wait_end;
      int n;
      for (n = 0; n < 3000; n++) begin
         @(negedge clk);
         if (done === 1'b1 || merr === 1'b1) begin
            return;
         end
      end
      err_total++;
      $display("unexpected timeout waiting for homing end");
      test_done();
   endtask

   task automatic run(input logic [7:0] code, input logic [31:0] p, input logic dir, input logic hi_spd,
                      input logic [31:0] lo, input logic [31:0] hi);
      wr_obj(16'h6098, 8'h00, code);
      place_go(p);
      cmp_bit("done_clear", 1'b0, done);
      cmp_bit("move_dir", dir, move_dir);
      cmp_bit("move_high", hi_spd, move_high);
      wait_end();
      cmp_bit("done", 1'b1, done);
      cmp_bit("method_err", 1'b0, merr);
      cmp_bit("busy", 1'b0, busy);
      cmp_pos(lo, hi);
   endtask

   // ==========================================
   // scenarios
   task automatic t_write;
      wr_obj(16'h6098, 8'h00, `HSR_M34);
      wr_obj(16'h6099, 8'h00, `HSR_M33);
      wr_obj(16'h6098, 8'h01, `HSR_M33);
      place_go(32'h000000C8);
      cmp_bit("move_dir", 1'b1, move_dir);
      wait_end();
      cmp_pos(32'h00000100, 32'h00000107);
      $display("test write done");
   endtask

   task automatic t_m27_28;
      run(`HSR_M27, 32'h000000C8, 1'b0, 1'b1, 32'h0000008D, 32'h00000094);
      run(`HSR_M27, 32'h00000078, 1'b1, 1'b0, 32'h0000008D, 32'h00000094);
      run(`HSR_M27, 32'h00000050, 1'b0, 1'b1, 32'h00000082, 32'h0000008C);
      run(`HSR_M28, 32'h000000C8, 1'b0, 1'b1, 32'h00000082, 32'h0000008C);
      run(`HSR_M28, 32'h00000078, 1'b1, 1'b0, 32'h00000082, 32'h0000008C);
      run(`HSR_M28, 32'h00000050, 1'b0, 1'b1, 32'h00000082, 32'h0000008C);
      $display("test m27 m28 done");
   endtask

   task automatic t_m29_30;
      run(`HSR_M29, 32'h000000C8, 1'b0, 1'b1, 32'h00000064, 32'h0000006B);
      run(`HSR_M29, 32'h00000078, 1'b0, 1'b1, 32'h00000064, 32'h0000006B);
      run(`HSR_M29, 32'h00000050, 1'b0, 1'b1, 32'h00000064, 32'h0000006B);
      run(`HSR_M30, 32'h000000C8, 1'b0, 1'b1, 32'h0000005C, 32'h00000063);
      run(`HSR_M30, 32'h00000078, 1'b0, 1'b1, 32'h0000005C, 32'h00000063);
      run(`HSR_M30, 32'h00000050, 1'b0, 1'b1, 32'h0000005C, 32'h00000063);
      $display("test m29 m30 done");
   endtask

   task automatic t_index;
      run(`HSR_M33, 32'h000000C8, 1'b0, 1'b0, 32'h000000BC, 32'h000000C3);
      run(`HSR_M34, 32'h000000C8, 1'b1, 1'b0, 32'h00000100, 32'h00000107);
      $display("test index done");
   endtask

   task automatic t_reserved;
      logic [7:0] codes [4];
      int i;
      codes = '{`HSR_M31, `HSR_M32, 8'h1A, 8'h23};
      for (i = 0; i < 4; i++) begin
         wr_obj(16'h6098, 8'h00, codes[i]);
         place_go(32'h000000C8);
         cmp_bit("method_err", 1'b1, merr);
         cmp_bit("move_en", 1'b0, move_en);
         cmp_bit("done", 1'b0, done);
      end
      $display("test reserved done");
   endtask

   task automatic t_limit;
      wr_obj(16'h6098, 8'h00, `HSR_M33);
      place_go(32'h0000000A);
      cmp_bit("move_en", 1'b0, move_en);
      wait_end();
      cmp_bit("method_err", 1'b1, merr);
      cmp_bit("done", 1'b0, done);
      $display("test limit done");
   endtask

   // reset in mid search drops motion and forgets the method
   task automatic t_reset;
      wr_obj(16'h6098, 8'h00, `HSR_M34);
      place_go(32'h000000C8);
      cmp_bit("busy", 1'b1, busy);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      cmp_bit("move_en", 1'b0, move_en);
      cmp_bit("busy", 1'b0, busy);
      cmp_bit("done", 1'b0, done);
      place_go(32'h000000C8);
      cmp_bit("method_err", 1'b1, merr);
      cmp_bit("move_en", 1'b0, move_en);
      $display("test reset done");
   endtask

   // ==========================================
   // main sequence
   initial begin
      err_total = 0;
      compares  = 0;
      rst_n     = 1'b0;
      wr_stb    = 1'b0;
      obj_index = 16'h0000;
      obj_sub   = 8'h00;
      obj_data  = 8'h00;
      start     = 1'b0;
      load_en   = 1'b0;
      load_val  = 32'h00000000;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_write();
      t_m27_28();
      t_m29_30();
      t_index();
      t_reserved();
      t_limit();
      t_reset();
      test_done();
   end
endmodule
